// >>> mofwc_ctrl.sv
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module mofwc_ctrl
(
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HWDATA_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic TX_FRAME_START_I,
    input wire mofwc_pkg::mofwc_csum_t TX_DESC_CSUM_I,
    output mofwc_pkg::mofwc_csum_t TX_CSUM_INS_O,
    input wire logic RX_FRAME_DONE_I,
    input wire mofwc_pkg::mofwc_csum_t RX_CSUM_STATUS_I,
    output logic RX_DESC_W0_WE_O,
    output mofwc_pkg::mofwc_csum_t RX_DESC_W0_CSUM_O,
    input wire logic PAUSE_COND_A_I,
    input wire logic PAUSE_COND_B_I,
    output logic TX_PAUSE_REQ_O,
    output logic [15:0] TX_PAUSE_TIME_O,
    input wire logic TX_PAUSE_SENT_I,
    input wire logic RX_PAUSE_DEC_I,
    output logic RX_PAUSE_HONOR_O,
    output logic VLAN_LEN_MODE_O,
    output logic RX_WDOG_EN_O,
    input wire logic RX_WDOG_EXPIRED_I,
    input wire logic RX_BIT_TICK_I,
    output logic RX_CHAN_EN_O,
    output logic TX_JABBER_EN_O,
    output logic IRQ_O
);
    import mofwc_pkg::*;

    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic send_zero_r;
    logic send_zero_nxt;
    logic send_max_r;
    logic send_max_nxt;
    logic auto_r;
    logic auto_nxt;
    logic cond_r;
    logic rx_latch_r;
    logic live_r;
    logic [IRQ_W-1:0] stat_r;
    logic [IRQ_W-1:0] stat_nxt;
    logic [IRQ_W-1:0] mask_r;
    logic [IRQ_W-1:0] events;
    logic [7:0] addr_r;
    logic wr_pend_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_ctrl;
    logic [31:0] rd_val;
    logic accept;
    logic rd_accept;
    logic rd_ctrl_accept;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic cond_met;
    logic sel_max;
    logic pause_done;
    logic live;
    logic wdog_start;
    logic wdog_busy;
    logic wdog_done;
    mofwc_csum_t ins_r;
    mofwc_csum_t ins_nxt;
    logic rx_we_r;
    mofwc_csum_t rx_csum_r;

    // Zero-wait slave: the address phase is taken whenever the bus is ready.
    assign accept = HSEL_I && HREADY_I && HTRANS_I[1];
    assign rd_accept = accept && !HWRITE_I;
    assign rd_ctrl_accept = rd_accept && HADDR_I[7:0] == OFS_CTRL;
    assign wr_ctrl = wr_pend_r && addr_r == OFS_CTRL;
    assign wr_stat = wr_pend_r && addr_r == OFS_STAT;
    assign wr_mask = wr_pend_r && addr_r == OFS_MASK;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end
        else
        begin
            wr_pend_r <= accept && HWRITE_I;
            if (accept)
                addr_r <= HADDR_I[7:0];
        end
    end

    always_comb
    begin
        rd_ctrl = ctrl_r & CTRL_STATIC_MASK;
        rd_ctrl[BIT_SEND_ZERO] = send_zero_r;
        rd_ctrl[BIT_SEND_MAX] = send_max_r;
        rd_ctrl[BIT_RX_LATCH] = rx_latch_r;
        rd_ctrl[BIT_RX_LIVE] = live_r;
        unique case (HADDR_I[7:0])
            OFS_CTRL: rd_val = rd_ctrl;
            OFS_STAT: rd_val = {29'h0000_0000, stat_r};
            OFS_MASK: rd_val = {29'h0000_0000, mask_r};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            rdata_r <= 32'h0000_0000;
        else if (rd_accept)
            rdata_r <= rd_val;
    end

    assign HRDATA_O = rdata_r;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    // Static control fields take the written value; reserved bits stay zero.
    assign ctrl_nxt = wr_ctrl ? (HWDATA_I & CTRL_STATIC_MASK) : ctrl_r;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            ctrl_r <= CTRL_RESET;
        else
            ctrl_r <= ctrl_nxt;
    end

    // Transmit checksum insertion is fixed for a frame at its start.
    always_comb
    begin
        ins_nxt.ip = ctrl_r[BIT_IP_ALL]
            || (ctrl_r[BIT_CSUM_DESC] && TX_DESC_CSUM_I.ip);
        ins_nxt.tcp = ctrl_r[BIT_TCP_ALL]
            || (ctrl_r[BIT_CSUM_DESC] && TX_DESC_CSUM_I.tcp);
        ins_nxt.udp = ctrl_r[BIT_UDP_ALL]
            || (ctrl_r[BIT_CSUM_DESC] && TX_DESC_CSUM_I.udp);
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            ins_r <= '0;
        else if (TX_FRAME_START_I)
            ins_r <= ins_nxt;
    end

    assign TX_CSUM_INS_O = ins_r;

    // Receive checksum status is passed to the descriptor writer when enabled.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            rx_we_r <= 1'b0;
            rx_csum_r <= '0;
        end
        else
        begin
            rx_we_r <= RX_FRAME_DONE_I && ctrl_r[BIT_RX_CSUM];
            if (RX_FRAME_DONE_I && ctrl_r[BIT_RX_CSUM])
                rx_csum_r <= RX_CSUM_STATUS_I;
        end
    end

    assign RX_DESC_W0_WE_O = rx_we_r;
    assign RX_DESC_W0_CSUM_O = rx_csum_r;

    // A new pause condition queues one max-time pause frame.
    assign cond_met = ctrl_r[BIT_COND_SEL] ? (PAUSE_COND_A_I || PAUSE_COND_B_I)
        : (PAUSE_COND_A_I && PAUSE_COND_B_I);
    assign sel_max = send_max_r || auto_r;
    assign pause_done = TX_PAUSE_SENT_I && TX_PAUSE_REQ_O;
    assign TX_PAUSE_REQ_O = send_zero_r || send_max_r || auto_r;
    assign TX_PAUSE_TIME_O = sel_max ? PAUSE_TIME_MAX : PAUSE_TIME_ZERO;

    always_comb
    begin
        send_zero_nxt = wr_ctrl ? HWDATA_I[BIT_SEND_ZERO] : send_zero_r;
        if (pause_done && !sel_max && !(wr_ctrl && HWDATA_I[BIT_SEND_ZERO]))
            send_zero_nxt = 1'b0;
        send_max_nxt = wr_ctrl ? HWDATA_I[BIT_SEND_MAX] : send_max_r;
        if (pause_done && sel_max && !(wr_ctrl && HWDATA_I[BIT_SEND_MAX]))
            send_max_nxt = 1'b0;
        auto_nxt = auto_r;
        if (pause_done && sel_max)
            auto_nxt = 1'b0;
        if (cond_met && !cond_r)
            auto_nxt = 1'b1;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            send_zero_r <= 1'b0;
            send_max_r <= 1'b0;
            auto_r <= 1'b0;
            cond_r <= 1'b0;
        end
        else
        begin
            send_zero_r <= send_zero_nxt;
            send_max_r <= send_max_nxt;
            auto_r <= auto_nxt;
            cond_r <= cond_met;
        end
    end

    // Pause decoding; a read of the control word clears the latch unless a decode arrives.
    assign live = RX_PAUSE_DEC_I && ctrl_r[BIT_FLOW_EN];

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            live_r <= 1'b0;
            rx_latch_r <= 1'b0;
        end
        else
        begin
            live_r <= live;
            if (live)
                rx_latch_r <= 1'b1;
            else if (rd_ctrl_accept)
                rx_latch_r <= 1'b0;
        end
    end

    assign RX_PAUSE_HONOR_O = live_r;

    assign VLAN_LEN_MODE_O = ctrl_r[BIT_VLAN];
    assign RX_WDOG_EN_O = !ctrl_r[BIT_WDOG_DIS];
    assign TX_JABBER_EN_O = !ctrl_r[BIT_JAB_DIS];

    // The receive channel is held off for the release interval after expiry.
    assign wdog_start = RX_WDOG_EXPIRED_I && !ctrl_r[BIT_WDOG_DIS];

    mofwc_bit_timer u_release
    (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .start_i(wdog_start),
        .long_i(ctrl_r[BIT_WDOG_REL]),
        .tick_i(RX_BIT_TICK_I),
        .busy_o(wdog_busy),
        .done_o(wdog_done)
    );

    assign RX_CHAN_EN_O = !wdog_busy;

    // Sticky status bits: write one to clear, a new event wins over the clear.
    assign events = {wdog_done, live && !live_r, pause_done};
    assign stat_nxt = (stat_r & ~(wr_stat ? HWDATA_I[IRQ_W-1:0] : IRQ_RESET)) | events;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            stat_r <= IRQ_RESET;
        else
            stat_r <= stat_nxt;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            mask_r <= IRQ_RESET;
        else if (wr_mask)
            mask_r <= HWDATA_I[IRQ_W-1:0];
    end

    assign IRQ_O = |(stat_r & mask_r);

    property p_desc_gate;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        TX_FRAME_START_I && !ctrl_r[BIT_CSUM_DESC] && !ctrl_r[BIT_IP_ALL] |=> !TX_CSUM_INS_O.ip;
    endproperty
    a_desc_gate: assert property (p_desc_gate) else $error("ip checksum without request");

    property p_ip_all;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        TX_FRAME_START_I && ctrl_r[BIT_IP_ALL] |=> TX_CSUM_INS_O.ip;
    endproperty
    a_ip_all: assert property (p_ip_all) else $error("ip checksum not forced");

    property p_tcp_all;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        TX_FRAME_START_I && ctrl_r[BIT_TCP_ALL] |=> TX_CSUM_INS_O.tcp;
    endproperty
    a_tcp_all: assert property (p_tcp_all) else $error("tcp checksum not forced");

    property p_udp_all;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        TX_FRAME_START_I && ctrl_r[BIT_UDP_ALL] |=> TX_CSUM_INS_O.udp;
    endproperty
    a_udp_all: assert property (p_udp_all) else $error("udp checksum not forced");

    property p_rx_report;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        RX_FRAME_DONE_I |=> RX_DESC_W0_WE_O == $past(ctrl_r[BIT_RX_CSUM])
            && (!RX_DESC_W0_WE_O || RX_DESC_W0_CSUM_O == $past(RX_CSUM_STATUS_I));
    endproperty
    a_rx_report: assert property (p_rx_report) else $error("rx checksum report wrong");

    property p_cond;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        $rose(cond_met) |=> TX_PAUSE_REQ_O && TX_PAUSE_TIME_O == PAUSE_TIME_MAX;
    endproperty
    a_cond: assert property (p_cond) else $error("pause condition ignored");

    property p_zero;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        pause_done && !sel_max && !wr_ctrl ##1 !auto_r |-> !send_zero_r;
    endproperty
    a_zero: assert property (p_zero) else $error("zero pause not cleared");

    property p_max;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        send_max_r |-> TX_PAUSE_REQ_O && TX_PAUSE_TIME_O == PAUSE_TIME_MAX;
    endproperty
    a_max: assert property (p_max) else $error("max pause time wrong");

    property p_flow;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !$past(ctrl_r[BIT_FLOW_EN]) |-> !RX_PAUSE_HONOR_O;
    endproperty
    a_flow: assert property (p_flow) else $error("pause acted on while disabled");

    property p_latch;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        rd_ctrl_accept && !live ##1 !live |-> !rx_latch_r [*2];
    endproperty
    a_latch: assert property (p_latch) else $error("pause latch not cleared by read");

    property p_wdog;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        wdog_start |=> !RX_CHAN_EN_O [*8];
    endproperty
    a_wdog: assert property (p_wdog) else $error("receive channel not held");

    property p_rsvd;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        rd_ctrl_accept |=> (HRDATA_O & ~CTRL_READ_MASK) == 32'h0000_0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
endmodule : mofwc_ctrl

// >>> mofwc_pkg.sv
// Function
// - Bit 31: checksums follow each transmit descriptor.
// - Bit 30: IP checksum into every transmit.
// - Bit 29: TCP checksum into every transmit.
// - Bit 28: UDP checksum into every transmit.
// - Bit 27: write receive checksum status out.
// - Bit 15: pause condition OR, else AND.
// - Bit 14: one zero-time pause, self-clears.
// - Bit 13: one max-time pause, self-clears.
// - Bit 10: act on received pause frames.
// - Bit 9: latched pause decode, read clears.
// - Bit 7: live pause decode, read only.
// - Bit 6: VLAN length mode enable.
// - Bit 4: receive watchdog disable.
// - Bit 0: transmit jabber disable.
package mofwc_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam int BIT_CSUM_DESC = 31;
    localparam int BIT_IP_ALL = 30;
    localparam int BIT_TCP_ALL = 29;
    localparam int BIT_UDP_ALL = 28;
    localparam int BIT_RX_CSUM = 27;
    localparam int BIT_COND_SEL = 15;
    localparam int BIT_SEND_ZERO = 14;
    localparam int BIT_SEND_MAX = 13;
    localparam int BIT_FLOW_EN = 10;
    localparam int BIT_RX_LATCH = 9;
    localparam int BIT_RX_LIVE = 7;
    localparam int BIT_VLAN = 6;
    localparam int BIT_WDOG_REL = 5;
    localparam int BIT_WDOG_DIS = 4;
    localparam int BIT_JAB_DIS = 0;
    localparam logic [31:0] CTRL_STATIC_MASK = 32'hf800_8471;
    localparam logic [31:0] CTRL_READ_MASK = 32'hf800_e6f1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int IRQ_W = 3;
    localparam int IRQ_PAUSE_SENT = 0;
    localparam int IRQ_PAUSE_RX = 1;
    localparam int IRQ_WDOG_REL = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic [15:0] PAUSE_TIME_ZERO = 16'h0000;
    localparam logic [15:0] PAUSE_TIME_MAX = 16'hffff;
    localparam int WDOG_LONG_MIN_BITS = 40;
    localparam int WDOG_LONG_MAX_BITS = 48;
    localparam int WDOG_SHORT_MIN_BITS = 16;
    localparam int WDOG_SHORT_MAX_BITS = 24;
    localparam logic [5:0] WDOG_LONG_TICKS = 6'((WDOG_LONG_MIN_BITS + WDOG_LONG_MAX_BITS) / 2);
    localparam logic [5:0] WDOG_SHORT_TICKS =
        6'((WDOG_SHORT_MIN_BITS + WDOG_SHORT_MAX_BITS) / 2);

    typedef struct packed {
        logic ip;
        logic tcp;
        logic udp;
    } mofwc_csum_t;
endpackage : mofwc_pkg

// >>> mofwc_bit_timer.sv
`timescale 1ns/1ns
module mofwc_bit_timer
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic long_i,
    input wire logic tick_i,
    output logic busy_o,
    output logic done_o
);
    import mofwc_pkg::*;

    logic [5:0] cnt_r;
    logic done_r;

    // Counts bit-time ticks down from the selected hold length.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            cnt_r <= 6'h00;
        else if (start_i)
            cnt_r <= long_i ? WDOG_LONG_TICKS : WDOG_SHORT_TICKS;
        else if (tick_i && cnt_r != 6'h00)
            cnt_r <= cnt_r - 6'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            done_r <= 1'b0;
        else
            done_r <= tick_i && !start_i && cnt_r == 6'h01;
    end

    assign busy_o = cnt_r != 6'h00;
    assign done_o = done_r;
endmodule : mofwc_bit_timer

// >>> test_mac_offload_flow_watchdog_ctrl.sv
`timescale 1ns/1ns
module test_mac_offload_flow_watchdog_ctrl;
    import mofwc_pkg::*;
    logic CLK_SYS_I = 1'b0;
    logic RST_N_I = 1'b0;
    logic HSEL_I = 1'b0;
    logic [31:0] HADDR_I = 32'h0;
    logic [1:0] HTRANS_I = 2'h0;
    logic HWRITE_I = 1'b0;
    logic [2:0] HSIZE_I = 3'h2;
    logic HREADY_I;
    logic [31:0] HWDATA_I = 32'h0;
    logic [31:0] HRDATA_O;
    logic HREADYOUT_O, HRESP_O;
    logic TX_FRAME_START_I = 1'b0;
    mofwc_csum_t TX_DESC_CSUM_I = '0;
    mofwc_csum_t TX_CSUM_INS_O, RX_DESC_W0_CSUM_O;
    logic RX_FRAME_DONE_I = 1'b0;
    mofwc_csum_t RX_CSUM_STATUS_I = '0;
    logic RX_DESC_W0_WE_O;
    logic PAUSE_COND_A_I = 1'b0;
    logic PAUSE_COND_B_I = 1'b0;
    logic TX_PAUSE_REQ_O;
    logic [15:0] TX_PAUSE_TIME_O;
    logic TX_PAUSE_SENT_I = 1'b0;
    logic RX_PAUSE_DEC_I = 1'b0;
    logic RX_PAUSE_HONOR_O, VLAN_LEN_MODE_O, RX_WDOG_EN_O;
    logic RX_WDOG_EXPIRED_I = 1'b0;
    logic RX_BIT_TICK_I = 1'b0;
    logic RX_CHAN_EN_O, TX_JABBER_EN_O, IRQ_O;
    int fails = 0;
    int n_checks = 0;
    logic [31:0] rdat;

    mofwc_ctrl DUT (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
        .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HREADY_I(HREADY_I),
        .HWDATA_I(HWDATA_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
        .TX_FRAME_START_I(TX_FRAME_START_I), .TX_DESC_CSUM_I(TX_DESC_CSUM_I),
        .TX_CSUM_INS_O(TX_CSUM_INS_O), .RX_FRAME_DONE_I(RX_FRAME_DONE_I),
        .RX_CSUM_STATUS_I(RX_CSUM_STATUS_I), .RX_DESC_W0_WE_O(RX_DESC_W0_WE_O),
        .RX_DESC_W0_CSUM_O(RX_DESC_W0_CSUM_O), .PAUSE_COND_A_I(PAUSE_COND_A_I),
        .PAUSE_COND_B_I(PAUSE_COND_B_I), .TX_PAUSE_REQ_O(TX_PAUSE_REQ_O),
        .TX_PAUSE_TIME_O(TX_PAUSE_TIME_O), .TX_PAUSE_SENT_I(TX_PAUSE_SENT_I),
        .RX_PAUSE_DEC_I(RX_PAUSE_DEC_I), .RX_PAUSE_HONOR_O(RX_PAUSE_HONOR_O),
        .VLAN_LEN_MODE_O(VLAN_LEN_MODE_O), .RX_WDOG_EN_O(RX_WDOG_EN_O),
        .RX_WDOG_EXPIRED_I(RX_WDOG_EXPIRED_I), .RX_BIT_TICK_I(RX_BIT_TICK_I),
        .RX_CHAN_EN_O(RX_CHAN_EN_O), .TX_JABBER_EN_O(TX_JABBER_EN_O), .IRQ_O(IRQ_O));

    // The only slave's ready is the bus ready.
    assign HREADY_I = HREADYOUT_O;

    always #25 CLK_SYS_I = ~CLK_SYS_I;

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_SYS_I);
        #1;
    endtask : cyc

    // The master waits on the slave's ready under a bounded count.
    task automatic wait_rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge CLK_SYS_I);
            k++;
        end while (HREADYOUT_O !== 1'b1 && k < 100);
        if (k >= 100)
        begin
            fails++;
            test_done();
        end
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge CLK_SYS_I);
        HSEL_I <= 1'b1;
        HTRANS_I <= 2'h2;
        HWRITE_I <= wr;
        HADDR_I <= {24'h0, a};
        wait_rdy();
        HSEL_I <= 1'b0;
        HTRANS_I <= 2'h0;
        HWDATA_I <= wd;
        wait_rdy();
        rd = HRDATA_O;
        #1;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rdat);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rdat);
        check(name, rdat, exp);
    endtask : rd_chk

    // Pulse index: 0 tx start, 1 rx done, 2 pause sent, 3 watchdog expired, 4 bit tick.
    task automatic pulse(input int k);
        @(posedge CLK_SYS_I);
        case (k)
            0: TX_FRAME_START_I <= 1'b1;
            1: RX_FRAME_DONE_I <= 1'b1;
            2: TX_PAUSE_SENT_I <= 1'b1;
            3: RX_WDOG_EXPIRED_I <= 1'b1;
            default: RX_BIT_TICK_I <= 1'b1;
        endcase
        @(posedge CLK_SYS_I);
        {TX_FRAME_START_I, RX_FRAME_DONE_I, TX_PAUSE_SENT_I, RX_WDOG_EXPIRED_I} <= 4'h0;
        RX_BIT_TICK_I <= 1'b0;
        #1;
    endtask : pulse

    task automatic t_reset_and_map;
        rd_chk("ctrl_reset", OFS_CTRL, 32'h0);
        check("wdog_en_reset", RX_WDOG_EN_O, 1'b1);
        check("jab_en_reset", TX_JABBER_EN_O, 1'b1);
        check("chan_en_reset", RX_CHAN_EN_O, 1'b1);
        wr(OFS_CTRL, 32'hffff_ffff);
        rd_chk("ctrl_all_ones", OFS_CTRL, 32'hf800_e471);
        check("vlan_on", VLAN_LEN_MODE_O, 1'b1);
        check("wdog_en_off", RX_WDOG_EN_O, 1'b0);
        check("jab_en_off", TX_JABBER_EN_O, 1'b0);
        wr(OFS_CTRL, 32'h0);
        check("vlan_off", VLAN_LEN_MODE_O, 1'b0);
        check("jab_en_on", TX_JABBER_EN_O, 1'b1);
        check("req_cancel", TX_PAUSE_REQ_O, 1'b0);
        wr(8'h0c, 32'hffff_ffff);
        rd_chk("unmapped", 8'h0c, 32'h0);
        check("hresp_okay", HRESP_O, 1'b0);
    endtask : t_reset_and_map

    task automatic t_tx_csum;
        logic [3:0] mode [6] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'ha};
        logic [2:0] desc [6] = '{3'h7, 3'h5, 3'h0, 3'h0, 3'h0, 3'h4};
        logic [2:0] exp [6] = '{3'h0, 3'h5, 3'h4, 3'h2, 3'h1, 3'h6};
        for (int i = 0; i < 6; i++)
        begin
            wr(OFS_CTRL, {mode[i], 28'h0});
            TX_DESC_CSUM_I <= mofwc_csum_t'(desc[i]);
            pulse(0);
            check("tx_csum_ins", TX_CSUM_INS_O, exp[i]);
        end
    endtask : t_tx_csum

    task automatic t_rx_report;
        wr(OFS_CTRL, 32'h0800_0000);
        RX_CSUM_STATUS_I <= mofwc_csum_t'(3'h5);
        pulse(1);
        check("rx_we_on", RX_DESC_W0_WE_O, 1'b1);
        check("rx_status", RX_DESC_W0_CSUM_O, 3'h5);
        wr(OFS_CTRL, 32'h0);
        pulse(1);
        check("rx_we_off", RX_DESC_W0_WE_O, 1'b0);
    endtask : t_rx_report

    task automatic t_pause_cmd(input int bitn, input logic [15:0] t);
        wr(OFS_STAT, 32'h7);
        wr(OFS_MASK, 32'h0);
        wr(OFS_CTRL, 32'h1 << bitn);
        check("pause_req", TX_PAUSE_REQ_O, 1'b1);
        check("pause_time", TX_PAUSE_TIME_O, t);
        pulse(2);
        check("pause_req_done", TX_PAUSE_REQ_O, 1'b0);
        rd_chk("ctrl_selfclear", OFS_CTRL, 32'h0);
        rd_chk("stat_sent", OFS_STAT, 32'h1);
        check("irq_masked", IRQ_O, 1'b0);
        wr(OFS_MASK, 32'h1);
        check("irq_on", IRQ_O, 1'b1);
        wr(OFS_STAT, 32'h1);
        check("irq_cleared", IRQ_O, 1'b0);
        rd_chk("stat_cleared", OFS_STAT, 32'h0);
    endtask : t_pause_cmd

    task automatic t_pause_cond;
        wr(OFS_CTRL, 32'h0000_8000);
        PAUSE_COND_A_I <= 1'b1;
        cyc(3);
        check("cond_or_req", TX_PAUSE_REQ_O, 1'b1);
        check("cond_or_time", TX_PAUSE_TIME_O, PAUSE_TIME_MAX);
        pulse(2);
        PAUSE_COND_A_I <= 1'b0;
        wr(OFS_CTRL, 32'h0);
        PAUSE_COND_A_I <= 1'b1;
        cyc(3);
        check("cond_and_one", TX_PAUSE_REQ_O, 1'b0);
        PAUSE_COND_B_I <= 1'b1;
        cyc(3);
        check("cond_and_both", TX_PAUSE_REQ_O, 1'b1);
        pulse(2);
        PAUSE_COND_A_I <= 1'b0;
        PAUSE_COND_B_I <= 1'b0;
        cyc(1);
    endtask : t_pause_cond

    task automatic t_pause_rx;
        wr(OFS_STAT, 32'h7);
        wr(OFS_CTRL, 32'h0000_0400);
        RX_PAUSE_DEC_I <= 1'b1;
        cyc(3);
        check("honor_on", RX_PAUSE_HONOR_O, 1'b1);
        rd_chk("ctrl_live", OFS_CTRL, 32'h0000_0680);
        rd_chk("stat_pause_rx", OFS_STAT, 32'h2);
        RX_PAUSE_DEC_I <= 1'b0;
        cyc(3);
        rd_chk("ctrl_latched", OFS_CTRL, 32'h0000_0600);
        rd_chk("ctrl_read_clear", OFS_CTRL, 32'h0000_0400);
        wr(OFS_CTRL, 32'h0);
        RX_PAUSE_DEC_I <= 1'b1;
        cyc(3);
        check("honor_off", RX_PAUSE_HONOR_O, 1'b0);
        RX_PAUSE_DEC_I <= 1'b0;
        cyc(3);
    endtask : t_pause_rx

    // The interval is counted in bit ticks, so a pause without ticks must not end it.
    task automatic t_wdog(input logic long_sel, input int n);
        wr(OFS_STAT, 32'h7);
        wr(OFS_CTRL, long_sel ? 32'h20 : 32'h0);
        pulse(3);
        check("chan_off", RX_CHAN_EN_O, 1'b0);
        repeat (n - 1) pulse(4);
        cyc(3);
        check("chan_still_off", RX_CHAN_EN_O, 1'b0);
        pulse(4);
        cyc(2);
        check("chan_back", RX_CHAN_EN_O, 1'b1);
        rd_chk("stat_release", OFS_STAT, 32'h4);
        wr(OFS_CTRL, 32'h10);
        pulse(3);
        cyc(1);
        check("wdog_disabled", RX_CHAN_EN_O, 1'b1);
    endtask : t_wdog

    initial
    begin
        #(50 * 20000);
        fails++;
        test_done();
    end

    initial
    begin
        repeat (4) @(posedge CLK_SYS_I);
        RST_N_I <= 1'b1;
        cyc(1);
        t_reset_and_map();
        t_tx_csum();
        t_rx_report();
        t_pause_cmd(BIT_SEND_ZERO, PAUSE_TIME_ZERO);
        t_pause_cmd(BIT_SEND_MAX, PAUSE_TIME_MAX);
        t_pause_cond();
        t_pause_rx();
        t_wdog(1'b1, 44);
        t_wdog(1'b0, 20);
        test_done();
    end
endmodule : test_mac_offload_flow_watchdog_ctrl
